// File: design/pvs_pkg.sv
// Package: register map, defaults, timing and decode helpers
package pvs_pkg;

   // Register offsets
   localparam logic [7:0] PVS_OFS_RAMP   = 8'h07;
   localparam logic [7:0] PVS_OFS_LDO_A  = 8'h08;
   localparam logic [7:0] PVS_OFS_LDO_B  = 8'h09;
   localparam logic [7:0] PVS_OFS_BUCK1  = 8'h0A;

   // Field layout
   localparam int         PVS_CODE_W     = 3;
   localparam int         PVS_BUCK_W     = 6;
   localparam int         PVS_LO_LSB     = 0;
   localparam int         PVS_HI_LSB     = 4;
   localparam logic [7:0] PVS_RAMP_MASK  = 8'h07;
   localparam logic [7:0] PVS_LDO_MASK   = 8'h77;
   localparam logic [7:0] PVS_BUCK_MASK  = 8'h3F;

   // Reset values and ramp-rate codes
   localparam logic [7:0] PVS_RAMP_RESET = 8'h06;
   localparam logic [7:0] PVS_ZERO_RESET = 8'h00;
   localparam logic [5:0] PVS_BUCK2_RESET = 6'h10;
   localparam logic [2:0] PVS_RAMP_NOW   = 3'h7;
   localparam logic [2:0] PVS_RAMP_TOP   = 3'h6;

   // Strap defaults, indexed by {default_strap_b, default_strap_a}
   localparam logic [7:0] PVS_LDO_A_DEF [4] =
      '{8'h00, 8'h21, 8'h42, 8'h63};
   localparam logic [7:0] PVS_LDO_B_DEF [4] =
      '{8'h00, 8'h21, 8'h42, 8'h63};
   localparam logic [7:0] PVS_BUCK1_DEF [4] =
      '{8'h10, 8'h18, 8'h20, 8'h28};

   // Timing: one code step of 25 mV at the fastest 7.2 mV/us rate
   localparam int PVS_CLK_NS          = 5;
   localparam int PVS_STEP_UV         = 25000;
   localparam int PVS_FAST_UV_PER_US  = 7200;
   localparam int PVS_FAST_STEP_NS    =
      (PVS_STEP_UV * 1000) / PVS_FAST_UV_PER_US;
   localparam int PVS_FAST_STEP_CYC   =
      (PVS_FAST_STEP_NS / PVS_CLK_NS < 1) ? 1 :
      PVS_FAST_STEP_NS / PVS_CLK_NS;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pvs_req_t;

   typedef enum logic {
      PVS_LOCKOUT = 1'b0,
      PVS_RUN     = 1'b1
   } pvs_state_t;

   // Regulators a and c share one table
   function automatic logic [11:0] pvs_ldo_ac_mv(input logic [2:0] c);
      case (c)
         3'h0: return 12'h320;
         3'h1: return 12'h3E8;
         3'h2: return 12'h4B0;
         3'h3: return 12'h5DC;
         3'h4: return 12'h708;
         3'h5: return 12'h834;
         3'h6: return 12'h9C4;
         default: return 12'hAF0;
      endcase
   endfunction : pvs_ldo_ac_mv

   function automatic logic [11:0] pvs_ldo_b_mv(input logic [2:0] c);
      case (c)
         3'h0: return 12'h4B0;
         3'h1: return 12'h514;
         3'h2: return 12'h708;
         3'h3: return 12'hA28;
         3'h4: return 12'hA8C;
         3'h5: return 12'hAF0;
         3'h6: return 12'hB54;
         default: return 12'hBB8;
      endcase
   endfunction : pvs_ldo_b_mv

   function automatic logic [11:0] pvs_ldo_d_mv(input logic [2:0] c);
      case (c)
         3'h0: return 12'h3E8;
         3'h1: return 12'h4B0;
         3'h2: return 12'h514;
         3'h3: return 12'h708;
         3'h4: return 12'hA28;
         3'h5: return 12'hA8C;
         3'h6: return 12'hAF0;
         default: return 12'hBB8;
      endcase
   endfunction : pvs_ldo_d_mv

   // Step-down code to millivolts; top three codes step 100 mV
   function automatic logic [11:0] pvs_buck_mv(input logic [5:0] c);
      logic [11:0] lo;
      lo = {7'h00, c[4:0]};
      if (!c[5])
         return 12'(12'h320 + lo * 12'h019);
      else if (c[4:0] < 5'h1D)
         return 12'(12'h640 + lo * 12'h032);
      else
         return 12'(12'hC1C + (lo - 12'h01D) * 12'h064);
   endfunction : pvs_buck_mv

endpackage : pvs_pkg

// File: design/pvs_ramp.sv
// Converter-2 code stepper that walks toward its target at a set rate
`timescale 1ns/1ps
module pvs_ramp
   import pvs_pkg::*;
#(
   parameter int FAST_STEP_CYC = PVS_FAST_STEP_CYC,
   parameter int CNT_W         = 17
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [2:0]        rate_code,
   input  wire logic [5:0]        target_code,
   output logic      [5:0]        cur_code_ff,
   output logic                   busy_ff
);

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] period;
   logic             step_due;

   // Each slower code doubles the time per step
   assign period   = CNT_W'(FAST_STEP_CYC) << (PVS_RAMP_TOP - rate_code);
   assign step_due = (cnt_ff >= period - CNT_W'(1));

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cnt_ff <= '0;
      else if (cur_code_ff == target_code || rate_code == PVS_RAMP_NOW)
         cnt_ff <= '0;
      else if (step_due)
         cnt_ff <= '0;
      else
         cnt_ff <= cnt_ff + CNT_W'(1);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cur_code_ff <= PVS_BUCK2_RESET;
      else if (rate_code == PVS_RAMP_NOW)
         cur_code_ff <= target_code;
      else if (cur_code_ff != target_code && step_due)
      begin
         if (cur_code_ff < target_code)
            cur_code_ff <= cur_code_ff + 6'h01;
         else
            cur_code_ff <= cur_code_ff - 6'h01;
      end
   end

   // Done when the code is reached, not when the rail settles
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         busy_ff <= 1'b0;
      else
         busy_ff <= (cur_code_ff != target_code);
   end

endmodule : pvs_ramp

// File: design/pvs_voltage_regs.sv
// Voltage-select register group with strap-loaded defaults
`timescale 1ns/1ps
module pvs_voltage_regs
   import pvs_pkg::*;
#(
   parameter int FAST_STEP_CYC = PVS_FAST_STEP_CYC
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              default_strap_a,
   input  wire logic              default_strap_b,
   input  wire pvs_req_t          req,
   input  wire logic [5:0]        buck_two_target,
   output logic      [7:0]        rd_data_ff,
   output logic                   rd_valid_ff,
   output logic                   strap_done_ff,
   output logic      [7:0]        ramp_rate_select_ff,
   output logic      [7:0]        linear_reg_voltage_a_ff,
   output logic      [7:0]        linear_reg_voltage_b_ff,
   output logic      [7:0]        buck_one_voltage_ff,
   output logic      [11:0]       linear_reg_a_mv_ff,
   output logic      [11:0]       linear_reg_b_mv_ff,
   output logic      [11:0]       linear_reg_c_mv_ff,
   output logic      [11:0]       linear_reg_d_mv_ff,
   output logic      [11:0]       buck_converter_one_mv_ff,
   output logic      [11:0]       buck_converter_two_mv_ff,
   output logic      [5:0]        buck_converter_two_code,
   output logic                   buck_converter_two_busy
);

   pvs_state_t state_ff;
   logic [1:0] strap_idx;
   logic       load_now;
   logic       wr_ok;

   assign strap_idx = {default_strap_b, default_strap_a};
   assign load_now  = (state_ff == PVS_LOCKOUT);
   // Writes in the strap-load cycle are dropped so the load is whole
   assign wr_ok     = req.wr && (state_ff == PVS_RUN);

   // Reset is the lockout event; release ends lockout one edge later
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         state_ff <= PVS_LOCKOUT;
      else
      begin
         case (state_ff)
            PVS_LOCKOUT: state_ff <= PVS_RUN;
            PVS_RUN:     state_ff <= PVS_RUN;
            default:     state_ff <= PVS_LOCKOUT;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         strap_done_ff <= 1'b0;
      else if (load_now)
         strap_done_ff <= 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ramp_rate_select_ff <= PVS_RAMP_RESET;
      else if (wr_ok && req.addr == PVS_OFS_RAMP)
         ramp_rate_select_ff <= req.wdata & PVS_RAMP_MASK;
   end

   // Straps are sampled by the clock after release, never by the reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         linear_reg_voltage_a_ff <= PVS_ZERO_RESET;
      else if (load_now)
         linear_reg_voltage_a_ff <= PVS_LDO_A_DEF[strap_idx];
      else if (wr_ok && req.addr == PVS_OFS_LDO_A)
         linear_reg_voltage_a_ff <= req.wdata & PVS_LDO_MASK;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         linear_reg_voltage_b_ff <= PVS_ZERO_RESET;
      else if (load_now)
         linear_reg_voltage_b_ff <= PVS_LDO_B_DEF[strap_idx];
      else if (wr_ok && req.addr == PVS_OFS_LDO_B)
         linear_reg_voltage_b_ff <= req.wdata & PVS_LDO_MASK;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         buck_one_voltage_ff <= PVS_ZERO_RESET;
      else if (load_now)
         buck_one_voltage_ff <= PVS_BUCK1_DEF[strap_idx];
      else if (wr_ok && req.addr == PVS_OFS_BUCK1)
         buck_one_voltage_ff <= req.wdata & PVS_BUCK_MASK;
   end

   // Read answers one edge after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rd_data_ff <= 8'h00;
      else if (req.rd)
      begin
         case (req.addr)
            PVS_OFS_RAMP:  rd_data_ff <= ramp_rate_select_ff;
            PVS_OFS_LDO_A: rd_data_ff <= linear_reg_voltage_a_ff;
            PVS_OFS_LDO_B: rd_data_ff <= linear_reg_voltage_b_ff;
            PVS_OFS_BUCK1: rd_data_ff <= buck_one_voltage_ff;
            default:       rd_data_ff <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rd_valid_ff <= 1'b0;
      else
         rd_valid_ff <= req.rd;
   end

   // Rail levels in millivolts, one edge behind the registers
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         linear_reg_a_mv_ff       <= 12'h000;
         linear_reg_b_mv_ff       <= 12'h000;
         linear_reg_c_mv_ff       <= 12'h000;
         linear_reg_d_mv_ff       <= 12'h000;
         buck_converter_one_mv_ff <= 12'h000;
         buck_converter_two_mv_ff <= 12'h000;
      end
      else
      begin
         linear_reg_a_mv_ff <= pvs_ldo_ac_mv(
            linear_reg_voltage_a_ff[PVS_LO_LSB +: PVS_CODE_W]);
         linear_reg_b_mv_ff <= pvs_ldo_b_mv(
            linear_reg_voltage_a_ff[PVS_HI_LSB +: PVS_CODE_W]);
         linear_reg_c_mv_ff <= pvs_ldo_ac_mv(
            linear_reg_voltage_b_ff[PVS_LO_LSB +: PVS_CODE_W]);
         linear_reg_d_mv_ff <= pvs_ldo_d_mv(
            linear_reg_voltage_b_ff[PVS_HI_LSB +: PVS_CODE_W]);
         buck_converter_one_mv_ff <= pvs_buck_mv(
            buck_one_voltage_ff[PVS_BUCK_W-1:0]);
         buck_converter_two_mv_ff <= pvs_buck_mv(
            buck_converter_two_code);
      end
   end

   // Ramp pace follows the slew code; it gives no timing to converter 1
   pvs_ramp #(
      .FAST_STEP_CYC (FAST_STEP_CYC)
   ) u_ramp (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .rate_code   (ramp_rate_select_ff[PVS_CODE_W-1:0]),
      .target_code (buck_two_target),
      .cur_code_ff (buck_converter_two_code),
      .busy_ff     (buck_converter_two_busy)
   );

endmodule : pvs_voltage_regs

// File: testbench/pvs_host.sv
// Host model driving the register strobe port
`timescale 1ns/1ps
module pvs_host
   import pvs_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] rd_data_ff,
   output pvs_req_t        req
);
   initial req = '0;
   // Strobe held one whole cycle, launched off the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(negedge clk_sys);
      req = '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk_sys);
      req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(negedge clk_sys);
      req = '0;
      q = rd_data_ff;
   endtask : rd
endmodule : pvs_host

// File: testbench/pvs_voltage_regs_asserts.sv
// Checker for the voltage-select register group
`timescale 1ns/1ps
module pvs_voltage_regs_asserts
   import pvs_pkg::*;
#(
   parameter int FAST_STEP_CYC = PVS_FAST_STEP_CYC
)
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       default_strap_a,
   input wire logic       default_strap_b,
   input wire pvs_req_t   req,
   input wire logic [5:0] buck_two_target,
   input wire logic [7:0] rd_data_ff,
   input wire logic       rd_valid_ff,
   input wire logic       strap_done_ff,
   input wire logic [7:0] ramp_rate_select_ff,
   input wire logic [7:0] linear_reg_voltage_a_ff,
   input wire logic [7:0] linear_reg_voltage_b_ff,
   input wire logic [7:0] buck_one_voltage_ff,
   input wire logic [5:0] buck_converter_two_code,
   input wire logic       buck_converter_two_busy
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   AST_RAMP_RO: assert property (ramp_rate_select_ff[7:3] == 5'h00)
      else $error("ramp register upper bits set");
   AST_LDOA_RO: assert property (
      (linear_reg_voltage_a_ff & 8'h88) == 8'h00)
      else $error("regulator a/b register zero bits set");
   AST_LDOB_RO: assert property (
      (linear_reg_voltage_b_ff & 8'h88) == 8'h00)
      else $error("regulator c/d register zero bits set");
   AST_BUCK_RO: assert property (buck_one_voltage_ff[7:6] == 2'h0)
      else $error("converter-1 register zero bits set");
   AST_RD_RAMP: assert property (req.rd && req.addr == PVS_OFS_RAMP |=>
      rd_valid_ff && rd_data_ff == $past(ramp_rate_select_ff))
      else $error("ramp register read wrong");
   AST_WR_MASK: assert property (req.wr && strap_done_ff &&
      req.addr == PVS_OFS_LDO_A |=>
      linear_reg_voltage_a_ff == ($past(req.wdata) & PVS_LDO_MASK))
      else $error("regulator a/b write not masked");
   AST_UNMAP: assert property (req.rd && req.addr == 8'h0B |=>
      rd_data_ff == 8'h00)
      else $error("unmapped read not zero");
   AST_STRAP: assert property ($rose(strap_done_ff) |->
      linear_reg_voltage_a_ff ==
      PVS_LDO_A_DEF[{$past(default_strap_b), $past(default_strap_a)}])
      else $error("strap default not loaded");
   AST_ONCE: assert property (strap_done_ff |=> strap_done_ff)
      else $error("strap latch dropped");
   AST_IMM: assert property (ramp_rate_select_ff[2:0] == PVS_RAMP_NOW &&
      buck_two_target != buck_converter_two_code |=>
      buck_converter_two_code == $past(buck_two_target))
      else $error("immediate code not applied");
   AST_STEP: assert property ($changed(buck_converter_two_code) &&
      $past(ramp_rate_select_ff[2:0]) != PVS_RAMP_NOW |->
      (buck_converter_two_code - $past(buck_converter_two_code))
      inside {6'h01, 6'h3F})
      else $error("ramp step larger than one code");
   AST_BUSY: assert property (buck_converter_two_code != buck_two_target
      |=> buck_converter_two_busy)
      else $error("busy not raised");
endmodule : pvs_voltage_regs_asserts

bind pvs_voltage_regs pvs_voltage_regs_asserts
   #(.FAST_STEP_CYC(FAST_STEP_CYC)) chk (.*);

// File: testbench/pvs_voltage_regs_test.sv
// Self-checking bench for the voltage-select register group
`timescale 1ns/1ps
module pvs_voltage_regs_test
   import pvs_pkg::*;
   ;
   localparam int FSC = 2;
   logic        clk_sys = 1'h0;
   logic        rst     = 1'h1;
   logic        sa      = 1'h0;
   logic        sb      = 1'h0;
   logic [5:0]  tgt     = 6'h10;
   pvs_req_t    req;
   logic [7:0]  rd_data, q;
   logic [11:0] mva, mvb, mvc, mvd, mv1, mv2;
   logic [5:0]  code2;
   logic        busy2, done;
   int          fails = 0;
   int          checks = 0;
   int          n;
   logic [23:0] rows [6] = '{24'h07FF07, 24'h07F800, 24'h08FF77,
                             24'h09AA22, 24'h0AFF3F, 24'h0B5500};
   logic [5:0]  bc [6] = '{6'h00, 6'h1F, 6'h20, 6'h3C, 6'h3D, 6'h3F};
   logic [11:0] tac [8] = '{12'h320, 12'h3E8, 12'h4B0, 12'h5DC,
                            12'h708, 12'h834, 12'h9C4, 12'hAF0};
   logic [11:0] tb2 [8] = '{12'h4B0, 12'h514, 12'h708, 12'hA28,
                            12'hA8C, 12'hAF0, 12'hB54, 12'hBB8};
   logic [11:0] td [8] = '{12'h3E8, 12'h4B0, 12'h514, 12'h708,
                           12'hA28, 12'hA8C, 12'hAF0, 12'hBB8};

   always #2.5 clk_sys = ~clk_sys;

   pvs_voltage_regs #(.FAST_STEP_CYC(FSC)) uut (
      .clk_sys(clk_sys), .rst(rst), .default_strap_a(sa),
      .default_strap_b(sb), .req(req), .buck_two_target(tgt),
      .rd_data_ff(rd_data), .rd_valid_ff(), .strap_done_ff(done),
      .ramp_rate_select_ff(), .linear_reg_voltage_a_ff(),
      .linear_reg_voltage_b_ff(), .buck_one_voltage_ff(),
      .linear_reg_a_mv_ff(mva), .linear_reg_b_mv_ff(mvb),
      .linear_reg_c_mv_ff(mvc), .linear_reg_d_mv_ff(mvd),
      .buck_converter_one_mv_ff(mv1), .buck_converter_two_mv_ff(mv2),
      .buck_converter_two_code(code2), .buck_converter_two_busy(busy2));
   pvs_host host (.clk_sys(clk_sys), .rd_data_ff(rd_data), .req(req));

   task automatic chk(input logic [11:0] s, input logic [11:0] e);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, q);
      chk({4'h0, q}, {4'h0, e});
   endtask : rd_chk
   task automatic do_reset(input logic [1:0] s);
      @(negedge clk_sys);
      rst = 1'h1;
      {sb, sa} = s;
      repeat (16) @(negedge clk_sys);
      rst = 1'h0;
      repeat (2) @(negedge clk_sys);
   endtask : do_reset
   function automatic logic [11:0] bmv(input logic [5:0] c);
      if (c < 6'h20)
         return 12'(12'h320 + 12'h019 * c);
      if (c < 6'h3D)
         return 12'(12'h640 + 12'h032 * (c - 6'h20));
      return 12'(12'hC1C + 12'h064 * (c - 6'h3D));
   endfunction : bmv
   // Window of two edges; the step counter is held at zero while the code sits on target
   task automatic ramp(input logic [2:0] rt, input logic [5:0] t);
      int e;
      e = (rt == PVS_RAMP_NOW) ? 1 : 2 * (FSC << (6 - rt));
      host.wr(PVS_OFS_RAMP, {5'h00, rt});
      @(negedge clk_sys);
      tgt = t;
      n = 0;
      while (code2 !== t && n < 2000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(12'(n >= e && n <= e + 2), 12'h001);
      @(posedge clk_sys);
      #1;
      chk({11'h000, busy2}, 12'h000);
      chk(mv2, bmv(t));
   endtask : ramp

   initial
   begin
      #100000;
      fails++;
      tally_and_finish();
   end

   initial
   begin
      do_reset(2'h0);
      rd_chk(PVS_OFS_RAMP, PVS_RAMP_RESET);
      for (int s = 0; s < 4; s++)
      begin
         do_reset(2'(s));
         chk({11'h000, done}, 12'h001);
         rd_chk(PVS_OFS_LDO_A, PVS_LDO_A_DEF[s]);
         rd_chk(PVS_OFS_LDO_B, PVS_LDO_B_DEF[s]);
         rd_chk(PVS_OFS_BUCK1, PVS_BUCK1_DEF[s]);
         {sb, sa} = ~2'(s);
         rd_chk(PVS_OFS_LDO_A, PVS_LDO_A_DEF[s]);
      end
      foreach (rows[i])
      begin
         host.wr(rows[i][23:16], rows[i][15:8]);
         rd_chk(rows[i][23:16], rows[i][7:0]);
      end
      for (int c = 0; c < 8; c++)
      begin
         host.wr(PVS_OFS_LDO_A, {1'h0, 3'(c), 1'h0, 3'(c)});
         host.wr(PVS_OFS_LDO_B, {1'h0, 3'(c), 1'h0, 3'(c)});
         @(negedge clk_sys);
         chk(mva, tac[c]);
         chk(mvb, tb2[c]);
         chk(mvc, tac[c]);
         chk(mvd, td[c]);
      end
      foreach (bc[i])
      begin
         host.wr(PVS_OFS_BUCK1, {2'h0, bc[i]});
         @(negedge clk_sys);
         chk(mv1, bmv(bc[i]));
      end
      ramp(PVS_RAMP_NOW, 6'h20);
      for (int r = 0; r < 7; r++)
         ramp(3'(r), r % 2 ? 6'h20 : 6'h22);
      ramp(PVS_RAMP_NOW, 6'h3F);
      // Mid-run lockout must undo the writes made above
      @(negedge clk_sys);
      tgt = 6'h10;
      do_reset(2'h2);
      rd_chk(PVS_OFS_RAMP, PVS_RAMP_RESET);
      rd_chk(PVS_OFS_LDO_A, PVS_LDO_A_DEF[2]);
      rd_chk(PVS_OFS_BUCK1, PVS_BUCK1_DEF[2]);
      tally_and_finish();
   end
endmodule : pvs_voltage_regs_test
